// >>> rtl/rlt_top.sv
// Purpose: command latency sequencer and latency table query port
// Assumes: SPI mode 0, pins sampled by mclk_i, SCK well below mclk/4
// Notes: SDR commands are judged against the top (133 MHz) row only
`timescale 1ns/1ps
module rlt_top (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic [1:0] lat_code_i,
   output logic so_o,
   output logic so_oe_o,
   output logic data_phase_o,
   output logic unsupported_o,
   output logic [7:0] mode_cycles_o,
   output logic [7:0] dummy_cycles_o,
   output logic [7:0] freq_limit_o
);
   typedef enum {
      ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
      ST_QOFF, ST_QOUT, ST_SKIP
   } rlt_state_type;

   logic [2:0] pins;
   logic sck;
   logic cs_n;
   logic si;
   logic sck_d;
   logic rise;
   logic fall;

   rlt_sync #(.W(3), .INIT(3'h2)) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({sck_i, cs_n_i, si_i}),
      .q_o(pins)
   );
   assign sck = pins[2];
   assign cs_n = pins[1];
   assign si = pins[0];
   assign rise = sck & ~sck_d;
   assign fall = ~sck & sck_d;

   // command decode of the byte being completed
   logic [7:0] cmd;
   logic [1:0] row;
   logic dec_known;
   logic dec_ok;
   logic dec_query;
   logic [7:0] dec_mode;
   logic [7:0] dec_dummy;
   logic [7:0] dec_addr;
   logic [7:0] dec_freq;
   logic [7:0] op;

   assign cmd = {op[6:0], si};
   assign row = lat_code_i + 2'b01;

   always_comb begin
      dec_known = 1'b1;
      dec_ok = 1'b1;
      dec_query = 1'b0;
      dec_mode = rlt_pkg::CYC_NOSUP;
      dec_dummy = rlt_pkg::CYC_NOSUP;
      dec_addr = (cmd[0] == cmd[1]) ? rlt_pkg::ADDR_BITS4
                                    : rlt_pkg::ADDR_BITS3;
      dec_freq = rlt_pkg::ROW_FREQ[row];
      case (cmd)
         rlt_pkg::OP_DDR_FAST3, rlt_pkg::OP_DDR_FAST4: begin
            dec_mode = rlt_pkg::DDR_FAST_MODE;
            dec_dummy = rlt_pkg::DDR_FAST_LAT[row];
            dec_addr = (cmd == rlt_pkg::OP_DDR_FAST4) ? 8'h10 : 8'h0c;
         end
         rlt_pkg::OP_DDR_DUAL3, rlt_pkg::OP_DDR_DUAL4: begin
            dec_mode = rlt_pkg::DDR_DUAL_MODE;
            dec_dummy = rlt_pkg::DDR_DUAL_LAT[row];
            dec_addr = (cmd == rlt_pkg::OP_DDR_DUAL4) ? 8'h08 : 8'h06;
         end
         rlt_pkg::OP_DDR_QUAD3, rlt_pkg::OP_DDR_QUAD4: begin
            dec_mode = rlt_pkg::DDR_QUAD_MODE;
            dec_dummy = rlt_pkg::DDR_QUAD_LAT[row];
            dec_addr = (cmd == rlt_pkg::OP_DDR_QUAD4) ? 8'h04 : 8'h03;
         end
         rlt_pkg::OP_FAST3, rlt_pkg::OP_FAST4: begin
            dec_mode = rlt_pkg::SDR_FAST_MODE;
            dec_dummy = rlt_pkg::SDR_FAST_LAT;
            dec_addr = (cmd == rlt_pkg::OP_FAST4) ? rlt_pkg::ADDR_BITS4
                                                 : rlt_pkg::ADDR_BITS3;
            dec_freq = rlt_pkg::SDR_TOP_FREQ;
         end
         // every other SDR read is marked FFh in the top row
         rlt_pkg::OP_READ3, rlt_pkg::OP_READ4, rlt_pkg::OP_DOUT3,
         rlt_pkg::OP_DOUT4, rlt_pkg::OP_QOUT3, rlt_pkg::OP_QOUT4,
         rlt_pkg::OP_DIO3, rlt_pkg::OP_DIO4, rlt_pkg::OP_QIO3,
         rlt_pkg::OP_QIO4: begin
            dec_ok = 1'b0;
            dec_freq = rlt_pkg::SDR_TOP_FREQ;
         end
         rlt_pkg::OP_QUERY: begin
            dec_query = 1'b1;
            dec_mode = 8'h00;
            dec_dummy = 8'h00;
         end
         default: begin
            dec_known = 1'b0;
            dec_ok = 1'b0;
         end
      endcase
   end

   // main sequence
   rlt_state_type state;
   rlt_state_type next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] next_op;
   logic [7:0] addr_len;
   logic [7:0] next_addr_len;
   logic [7:0] qaddr;
   logic [7:0] next_qaddr;
   logic [2:0] bitn;
   logic [2:0] next_bitn;
   logic so;
   logic next_so;
   logic so_oe;
   logic next_so_oe;
   logic data_phase;
   logic next_data_phase;
   logic unsup;
   logic next_unsup;
   logic [7:0] mode_r;
   logic [7:0] next_mode_r;
   logic [7:0] dummy_r;
   logic [7:0] next_dummy_r;
   logic [7:0] freq_r;
   logic [7:0] next_freq_r;
   logic [7:0] rom_q;

   rlt_rom u_rom (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .idx_i(qaddr),
      .data_o(rom_q)
   );

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_op = op;
      next_addr_len = addr_len;
      next_qaddr = qaddr;
      next_bitn = bitn;
      next_so = so;
      next_so_oe = so_oe;
      next_data_phase = data_phase;
      next_unsup = unsup;
      next_mode_r = mode_r;
      next_dummy_r = dummy_r;
      next_freq_r = freq_r;
      if (cs_n) begin
         // deselect ends any transfer, whatever its phase
         next_state = ST_IDLE;
         next_so_oe = 1'b0;
         next_data_phase = 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_OPC;
               next_cnt = 8'h00;
               next_unsup = 1'b0;
            end
            ST_OPC: begin
               if (rise) begin
                  next_op = cmd;
                  next_cnt = cnt + 8'h01;
                  if (cnt == rlt_pkg::BITS_PER_BYTE - 8'h01) begin
                     next_cnt = 8'h00;
                     next_mode_r = dec_mode;
                     next_dummy_r = dec_dummy;
                     next_freq_r = dec_freq;
                     next_addr_len = dec_addr;
                     next_unsup = dec_known & ~dec_ok;
                     if (dec_query) begin
                        next_state = ST_QOFF;
                     end else if (dec_ok) begin
                        next_state = ST_ADDR;
                     end else begin
                        next_state = ST_SKIP;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  next_cnt = cnt + 8'h01;
                  if (cnt == addr_len - 8'h01) begin
                     next_cnt = 8'h00;
                     if (mode_r != 8'h00) begin
                        next_state = ST_MODE;
                     end else if (dummy_r != 8'h00) begin
                        next_state = ST_DUMMY;
                     end else begin
                        next_state = ST_DATA;
                        next_data_phase = 1'b1;
                     end
                  end
               end
            end
            ST_MODE: begin
               if (rise) begin
                  next_cnt = cnt + 8'h01;
                  if (cnt == mode_r - 8'h01) begin
                     next_cnt = 8'h00;
                     if (dummy_r != 8'h00) begin
                        next_state = ST_DUMMY;
                     end else begin
                        next_state = ST_DATA;
                        next_data_phase = 1'b1;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  next_cnt = cnt + 8'h01;
                  if (cnt == dummy_r - 8'h01) begin
                     next_state = ST_DATA;
                     next_data_phase = 1'b1;
                  end
               end
            end
            ST_QOFF: begin
               if (rise) begin
                  next_qaddr = {qaddr[6:0], si};
                  next_cnt = cnt + 8'h01;
                  if (cnt == rlt_pkg::BITS_PER_BYTE - 8'h01) begin
                     next_state = ST_QOUT;
                     next_bitn = 3'h0;
                  end
               end
            end
            ST_QOUT: begin
               // rom_q settles one mclk after qaddr moves, long before
               // the next falling SCK edge
               if (fall) begin
                  next_so = rom_q[3'h7 - bitn];
                  next_so_oe = 1'b1;
                  next_bitn = bitn + 3'h1;
                  if (bitn == 3'h7) begin
                     next_qaddr = qaddr + 8'h01;
                  end
               end
            end
            ST_DATA, ST_SKIP: begin
               next_state = state;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sck_d <= 1'b0;
         state <= ST_IDLE;
         cnt <= 8'h00;
         op <= 8'h00;
         addr_len <= 8'h00;
         qaddr <= 8'h00;
         bitn <= 3'h0;
         so <= 1'b0;
         so_oe <= 1'b0;
         data_phase <= 1'b0;
         unsup <= 1'b0;
         mode_r <= 8'h00;
         dummy_r <= 8'h00;
         freq_r <= 8'h00;
      end else if (ce_i) begin
         sck_d <= sck;
         state <= next_state;
         cnt <= next_cnt;
         op <= next_op;
         addr_len <= next_addr_len;
         qaddr <= next_qaddr;
         bitn <= next_bitn;
         so <= next_so;
         so_oe <= next_so_oe;
         data_phase <= next_data_phase;
         unsup <= next_unsup;
         mode_r <= next_mode_r;
         dummy_r <= next_dummy_r;
         freq_r <= next_freq_r;
      end
   end

   assign so_o = so;
   assign so_oe_o = so_oe;
   assign data_phase_o = data_phase;
   assign unsupported_o = unsup;
   assign mode_cycles_o = mode_r;
   assign dummy_cycles_o = dummy_r;
   assign freq_limit_o = freq_r;

   logic opc_done;
   assign opc_done = ce_i && !cs_n && state == ST_OPC && rise && cnt == 8'h07;

   a_top_fast: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && cmd inside {8'h0b, 8'h0c}
      |=> mode_cycles_o == 8'h00 && dummy_cycles_o == 8'h08
          && freq_limit_o == 8'h85)
      else $error("top row fast read cycles wrong");
   a_top_nosup: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && cmd inside {8'h3b, 8'h6b, 8'hbb, 8'hec, 8'h03}
      |=> dummy_cycles_o == 8'hff && unsupported_o)
      else $error("unsupported top row entry not FFh");
   a_nosup_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      unsupported_o && !cs_n |-> !data_phase_o && !so_oe_o)
      else $error("refused command reached data phase");
   a_code11: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && lat_code_i == 2'b11 && cmd inside {8'h0d, 8'hbe, 8'hed}
      |=> dummy_cycles_o == ((op == 8'hed) ? 8'h03 : 8'h04)
          && freq_limit_o == 8'h32)
      else $error("code 11b dummy count wrong");
   a_code00: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && lat_code_i == 2'b00 && cmd inside {8'h0e, 8'hbd, 8'hee}
      |=> dummy_cycles_o == ((op == 8'h0e) ? 8'h05 : 8'h06))
      else $error("code 00b dummy count wrong");
   a_code01: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && lat_code_i == 2'b01 && cmd inside {8'h0d, 8'hbd, 8'hed}
      |=> dummy_cycles_o == ((op == 8'h0d) ? 8'h06 : 8'h07))
      else $error("code 01b dummy count wrong");
   a_code10: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && lat_code_i == 2'b10 && cmd inside {8'h0e, 8'hbe, 8'hee}
      |=> dummy_cycles_o == ((op == 8'h0e) ? 8'h07 : 8'h08)
          && freq_limit_o == 8'h42)
      else $error("code 10b dummy count wrong");
   a_quad_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
      opc_done && cmd inside {8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee}
      |=> mode_cycles_o == ((op[7:4] == 4'he) ? 8'h01 : 8'h00))
      else $error("DDR mode cycle count wrong");
   a_dummy_end: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && !cs_n && state == ST_DUMMY && rise && cnt == dummy_r - 8'h01
      |=> data_phase_o)
      else $error("data phase not started after dummy cycles");
endmodule : rlt_top

// >>> rtl/rlt_pkg.sv
// Purpose: constants of the read latency code table and its sequencer
// Assumes: 200 MHz mclk, SPI pins sampled by mclk
// Notes: table bytes and command decode share these constants
// Contract
// - top SDR row, code 10b: fast read has 0 mode, 8 dummy cycles
// - top SDR row: dual/quad out and dual/quad I/O entries read FFh
// - an FFh entry means the command is refused at that frequency
// - DDR parameter starts with id byte 9Ah then length byte 2Ah
// - header holds ASCII 46h and 43h at offsets four and five
// - DDR fast read opcodes 0Dh (3-byte) and 0Eh (4-byte) decoded
// - DDR dual I/O read opcodes BDh (3-byte) and BEh (4-byte)
// - DDR quad I/O read opcodes EDh (3-byte) and EEh (4-byte)
// - first DDR row limits SCK to 50 MHz with code 11b
// - code 11b: fast and dual 4 dummy cycles, quad 3
// - code 00b, 66 MHz: fast 5, dual and quad 6 dummy cycles
// - code 01b, 66 MHz: fast 6, dual and quad 7 dummy cycles
// - code 10b, 66 MHz: fast 7, dual and quad 8 dummy cycles
// - DDR quad I/O has one mode cycle, fast and dual none
// - latency code byte holds the two-bit code right-justified
// - frequency byte is the SCK limit in MHz, binary
// - top SDR row covers up to 133 MHz, encoded 85h
package rlt_pkg;
   // header of the DDR parameter
   localparam logic [7:0] PARAM_ID = 8'h9a;
   localparam logic [7:0] PARAM_LEN = 8'h2a;
   localparam logic [7:0] NUM_ROWS = 8'h05;
   localparam logic [7:0] ROW_LEN = 8'h08;
   localparam logic [7:0] HDR_FREQ = 8'h46;
   localparam logic [7:0] HDR_CODE = 8'h43;
   localparam logic [7:0] IDX_ID = 8'h00;
   localparam logic [7:0] IDX_LEN = 8'h01;
   localparam logic [7:0] IDX_NROWS = 8'h02;
   localparam logic [7:0] IDX_ROWLEN = 8'h03;
   localparam logic [7:0] IDX_HDR_F = 8'h04;
   localparam logic [7:0] IDX_HDR_C = 8'h05;
   localparam logic [7:0] IDX_OPS = 8'h06;
   localparam logic [7:0] IDX_ROWS = 8'h0c;
   localparam logic [7:0] IDX_LAST = 8'h2b;
   localparam logic [7:0] NOT_MAPPED = 8'hff;
   // DDR commands
   localparam logic [7:0] OP_DDR_FAST3 = 8'h0d;
   localparam logic [7:0] OP_DDR_FAST4 = 8'h0e;
   localparam logic [7:0] OP_DDR_DUAL3 = 8'hbd;
   localparam logic [7:0] OP_DDR_DUAL4 = 8'hbe;
   localparam logic [7:0] OP_DDR_QUAD3 = 8'hed;
   localparam logic [7:0] OP_DDR_QUAD4 = 8'hee;
   // SDR commands checked against the top row, then the query opcode
   localparam logic [7:0] OP_READ3 = 8'h03;
   localparam logic [7:0] OP_READ4 = 8'h13;
   localparam logic [7:0] OP_FAST3 = 8'h0b;
   localparam logic [7:0] OP_FAST4 = 8'h0c;
   localparam logic [7:0] OP_DOUT3 = 8'h3b;
   localparam logic [7:0] OP_DOUT4 = 8'h3c;
   localparam logic [7:0] OP_QOUT3 = 8'h6b;
   localparam logic [7:0] OP_QOUT4 = 8'h6c;
   localparam logic [7:0] OP_DIO3 = 8'hbb;
   localparam logic [7:0] OP_DIO4 = 8'hbc;
   localparam logic [7:0] OP_QIO3 = 8'heb;
   localparam logic [7:0] OP_QIO4 = 8'hec;
   localparam logic [7:0] OP_QUERY = 8'h5a;
   // DDR rows in table order, indexed by (code + 1) mod 4
   localparam logic [1:0] ROW_CODE [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
   localparam logic [7:0] ROW_FREQ [4] = '{8'h32, 8'h42, 8'h42, 8'h42};
   localparam logic [7:0] DDR_FAST_LAT [4] = '{8'h04, 8'h05, 8'h06, 8'h07};
   localparam logic [7:0] DDR_DUAL_LAT [4] = '{8'h04, 8'h06, 8'h07, 8'h08};
   localparam logic [7:0] DDR_QUAD_LAT [4] = '{8'h03, 8'h06, 8'h07, 8'h08};
   localparam logic [7:0] DDR_FAST_MODE = 8'h00;
   localparam logic [7:0] DDR_DUAL_MODE = 8'h00;
   localparam logic [7:0] DDR_QUAD_MODE = 8'h01;
   // top SDR row
   localparam logic [7:0] SDR_TOP_FREQ = 8'h85;
   localparam logic [1:0] SDR_TOP_CODE = 2'b10;
   localparam logic [7:0] SDR_FAST_MODE = 8'h00;
   localparam logic [7:0] SDR_FAST_LAT = 8'h08;
   localparam logic [7:0] CYC_NOSUP = 8'hff;
   // address bits per width; cycles are bits shifted by lanes and DDR
   localparam logic [7:0] ADDR_BITS3 = 8'h18;
   localparam logic [7:0] ADDR_BITS4 = 8'h20;
   localparam logic [7:0] BITS_PER_BYTE = 8'h08;
endpackage : rlt_pkg

// >>> rtl/rlt_sync.sv
// Purpose: two-flop synchroniser for pins, one chain per bit
// Assumes: inputs are asynchronous to mclk_i
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module rlt_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta;
         logic stab;
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               meta <= INIT[g];
               stab <= INIT[g];
            end else if (ce_i) begin
               meta <= d_i[g];
               stab <= meta;
            end
         end
         assign q_o[g] = stab;
      end
   endgenerate
endmodule : rlt_sync

// >>> rtl/rlt_rom.sv
// Purpose: DDR latency parameter bytes, registered lookup by offset
// Assumes: offset relative to the parameter id byte
// Notes: offsets past the parameter read FFh
`timescale 1ns/1ps
module rlt_rom (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] idx_i,
   output logic [7:0] data_o
);
   logic [7:0] data;
   logic [7:0] next_data;
   logic [7:0] rel;
   logic [1:0] row;

   always_comb begin
      rel = idx_i - rlt_pkg::IDX_ROWS;
      row = rel[4:3];
      next_data = rlt_pkg::NOT_MAPPED;
      case (idx_i)
         rlt_pkg::IDX_ID: next_data = rlt_pkg::PARAM_ID;
         rlt_pkg::IDX_LEN: next_data = rlt_pkg::PARAM_LEN;
         rlt_pkg::IDX_NROWS: next_data = rlt_pkg::NUM_ROWS;
         rlt_pkg::IDX_ROWLEN: next_data = rlt_pkg::ROW_LEN;
         rlt_pkg::IDX_HDR_F: next_data = rlt_pkg::HDR_FREQ;
         rlt_pkg::IDX_HDR_C: next_data = rlt_pkg::HDR_CODE;
         8'h06: next_data = rlt_pkg::OP_DDR_FAST3;
         8'h07: next_data = rlt_pkg::OP_DDR_FAST4;
         8'h08: next_data = rlt_pkg::OP_DDR_DUAL3;
         8'h09: next_data = rlt_pkg::OP_DDR_DUAL4;
         8'h0a: next_data = rlt_pkg::OP_DDR_QUAD3;
         8'h0b: next_data = rlt_pkg::OP_DDR_QUAD4;
         default: begin
            if (idx_i >= rlt_pkg::IDX_ROWS && idx_i <= rlt_pkg::IDX_LAST) begin
               case (rel[2:0])
                  3'h0: next_data = rlt_pkg::ROW_FREQ[row];
                  3'h1: next_data = {6'h00, rlt_pkg::ROW_CODE[row]};
                  3'h2: next_data = rlt_pkg::DDR_FAST_MODE;
                  3'h3: next_data = rlt_pkg::DDR_FAST_LAT[row];
                  3'h4: next_data = rlt_pkg::DDR_DUAL_MODE;
                  3'h5: next_data = rlt_pkg::DDR_DUAL_LAT[row];
                  3'h6: next_data = rlt_pkg::DDR_QUAD_MODE;
                  default: next_data = rlt_pkg::DDR_QUAD_LAT[row];
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         data <= 8'h00;
      end else if (ce_i) begin
         data <= next_data;
      end
   end
   assign data_o = data;

   a_id_len: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i == 8'h00 ##1 ce_i && idx_i == 8'h01
      |-> data_o == 8'h9a ##1 data_o == 8'h2a)
      else $error("parameter id or length byte wrong");
   a_hdr_ascii: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i inside {8'h04, 8'h05}
      |=> data_o == (($past(idx_i) == 8'h04) ? 8'h46 : 8'h43))
      else $error("header column label wrong");
   a_first_row: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i == 8'h0c ##1 ce_i && idx_i == 8'h0d
      |-> data_o == 8'h32 ##1 data_o == 8'h03)
      else $error("first DDR row not 50 MHz code 11b");
   a_code_just: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i inside {8'h15, 8'h1d, 8'h25}
      |=> data_o == {6'h00, $past(idx_i[4:3]) - 2'b10})
      else $error("latency code byte not right-justified");
   a_freq_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i inside {8'h14, 8'h1c, 8'h24} |=> data_o == 8'h42)
      else $error("66 MHz row limit byte wrong");
   a_ddr_ops: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && idx_i == 8'h06 ##1 ce_i && idx_i == 8'h07
      |-> data_o == 8'h0d ##1 data_o == 8'h0e)
      else $error("DDR fast read opcode bytes wrong");
endmodule : rlt_rom

// >>> verification/rlt_host.sv
// Purpose: SPI host model, one command per select frame
// Assumes: mode 0, SCK of 80 ns made from mclk falling edges
// Notes: SCK idles low; si flips after a frame so stale bits never match
`timescale 1ns/1ps
module rlt_host (
   input wire logic mclk_i,
   input wire logic so_i,
   output logic sck_o = 1'b0,
   output logic cs_n_o = 1'b1,
   output logic si_o = 1'b0
);
   int seed = 2;
   logic [15:0] rd;
   event done;
   task automatic half;
      repeat (8) @(negedge mclk_i);
   endtask : half
   // n cycles follow the opcode; the first eight carry offs
   task automatic frame(input logic [7:0] op, offs, input int n);
      @(negedge mclk_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < n + 8; i++) begin
         si_o = i < 8 ? op[7-i] : i < 16 ? offs[15-i] : 1'($random(seed));
         half();
         sck_o = 1'b1;
         rd = {rd[14:0], so_i};
         half();
         sck_o = 1'b0;
      end
      half();
      -> done;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      half();
   endtask : frame
endmodule : rlt_host

// >>> verification/testbench.sv
// Purpose: self-checking bench for the latency table sequencer
// Assumes: host model drives the pins; ce_i held high
// Notes: table values below are written out, never read from the design
`timescale 1ns/1ps
module testbench;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] lat_code_i = 2'b00;
   logic sck, cs_n, si, so, so_oe, dp, uns;
   logic [7:0] mode, dum, freq;
   int n_errors = 0;
   int compares = 0;
   logic [32:0] exp_q[$];
   logic [7:0] hdr[12] = '{8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
      8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};
   logic [7:0] lat[4][3] = '{'{8'h05, 8'h06, 8'h06},
      '{8'h06, 8'h07, 8'h07}, '{8'h07, 8'h08, 8'h08}, '{8'h04, 8'h04, 8'h03}};
   logic [7:0] fq[4] = '{8'h42, 8'h42, 8'h42, 8'h32};
   logic [7:0] sdr[12] = '{8'h0b, 8'h0c, 8'h03, 8'h13, 8'h3b, 8'h3c,
      8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
   int acyc[6] = '{12, 16, 6, 8, 3, 4};
   wire [31:0] status = {6'h0, uns, dp, mode, dum, freq};
   always #2.5 mclk_i = ~mclk_i;
   rlt_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .lat_code_i(lat_code_i),
      .so_o(so), .so_oe_o(so_oe), .data_phase_o(dp), .unsupported_o(uns),
      .mode_cycles_o(mode), .dummy_cycles_o(dum), .freq_limit_o(freq));
   // a released line reads as z so a sample there can never match
   rlt_host i_host (.mclk_i(mclk_i), .so_i(so_oe ? so : 1'bz),
      .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
   task automatic check(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic stop_test;
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   function automatic logic [7:0] rom(input int o);
      int r, c;
      if (o < 12) return hdr[o];
      if (o > 43) return 8'hff;
      r = (o - 12) % 8;
      c = ((o - 12) / 8 + 3) % 4;
      case (r)
         0: return fq[c];
         1: return 8'(c);
         2, 4: return 8'h00;
         3: return lat[c][0];
         5: return lat[c][1];
         6: return 8'h01;
         default: return lat[c][2];
      endcase
   endfunction : rom
   always @(i_host.done) begin : watch
      logic [32:0] e;
      e = exp_q.pop_front();
      if (e[32]) check({16'h0, i_host.rd}, e[31:0]);
      else check(status, e[31:0]);
   end
   initial begin
      int n, k, md;
      logic [7:0] row;
      repeat (5) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      // one cycle short of the data phase, then exactly on it
      for (int c = 0; c < 4; c++) begin
         lat_code_i = 2'(c);
         for (int j = 0; j < 6; j++) begin
            for (int d = 0; d < 2; d++) begin
               k = j / 2;
               md = int'(k == 2);
               row = lat[c][k];
               n = acyc[j] + md + int'(row) - 1 + d;
               exp_q.push_back({9'(d), 8'(md), row, fq[c]});
               i_host.frame(hdr[6 + j], 8'(n), n);
            end
         end
      end
      for (int j = 0; j < 12; j++) begin
         lat_code_i = 2'(j);
         if (j < 2) exp_q.push_back({9'h001, 8'h00, 8'h08, 8'h85});
         else exp_q.push_back({9'h002, 8'hff, 8'hff, 8'h85});
         i_host.frame(sdr[j], 8'h3c, 32 + 8 * j[0]);
      end
      // an opcode outside the table sets no flag and opens no data phase
      lat_code_i = 2'b11;
      exp_q.push_back({9'h000, 8'hff, 8'hff, fq[3]});
      i_host.frame(8'h9a, 8'h00, 40);
      for (int o = 0; o < 44; o++) begin
         exp_q.push_back({17'h10000, rom(o), rom(o + 1)});
         i_host.frame(8'h5a, 8'(o), 24);
      end
      // next parameter lies past this table, so only fill comes back
      exp_q.push_back({17'h10000, 8'hff, 8'hff});
      i_host.frame(8'h5a, 8'(1 + int'(rom(1)) + 1), 24);
      stop_test();
   end
   // the run needs about 51k mclk cycles; give up after 80k
   initial begin
      #400_000;
      n_errors++;
      stop_test();
   end
endmodule : testbench
